// File: rtl/pas_converter.sv
/*
  Pipelined sampling converter digital behaviour: start-edge detection, three-deep
  result pipeline, conversion timer, idle refresh timer and decay tracking.
  Assumes conv_clk_pin, analog words and strap pins are asynchronous to clk.
*/
//
// Behaviour
// - Each rising edge of the conversion clock that comes while no conversion is running captures both analog inputs together and starts a conversion.
// - A sample's result appears on the outputs two further taken start edges plus about 70 ns after it was taken.
// - A new conversion is taken on every start edge that finds no conversion running, while older samples are still in flight,
//   one result per taken edge from the third taken edge after reset or decay.
// - After 500 us without a start edge an internal timer refreshes the dynamic logic.
// - Each result is a 12-bit two's complement word with a separate out-of-range bit.
// - Gain select high gives unity gain, low gives double gain and half the span.
// - Reference select picks 4.096 V, 2.048 V or an external reference.
// - The out-of-range bit is high exactly when the word is the most negative or most positive code.
// - A conversion once begun runs to its end and is neither aborted nor restarted.
`timescale 1ns/1ps
module pas_converter #(
  parameter int REFRESH_CYC = pas_pkg::PAS_REFRESH_CYC,
  parameter int STALE_CYC = pas_pkg::PAS_STALE_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic conv_clk_pin,
  input wire pas_pkg::pas_sample_s analog_in,
  input wire logic gain_select,
  input wire pas_pkg::pas_ref_sel_e ref_select,
  input wire logic [pas_pkg::PAS_MV_W-1:0] ext_ref_mv,
  output pas_pkg::pas_result_s result,
  output logic refresh_pulse,
  output logic result_stale
);
  import pas_pkg::*;

  localparam int CNT_W = $clog2(REFRESH_CYC + 1);
  localparam int CONV_W = $clog2(PAS_CONV_CYC + 1);
  localparam int CONV_LAT = PAS_CONV_CYC;
  localparam int BUSY_LEN = PAS_CONV_CYC - 1;

  logic clk_meta_r, clk_sync_r, clk_prev_r;
  pas_sample_s ana_meta_r, ana_sync_r;
  logic gain_meta_r, gain_sync_r;
  pas_ref_sel_e ref_meta_r, ref_sync_r;
  logic [PAS_MV_W-1:0] ext_meta_r, ext_sync_r;

  logic start_edge;
  logic take;
  logic signed [PAS_DATA_W-1:0] q_code;
  logic [PAS_DATA_W-1:0] s0_r, s1_r, s2_r;
  logic s0_v_r, s1_v_r, s2_v_r;
  logic busy_r;
  logic [CONV_W-1:0] conv_cnt_r;
  logic done;
  logic upd;
  logic [CNT_W-1:0] idle_cnt_r;
  logic decay;

  // Pins are asynchronous; the meta stage feeds only the sync stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_meta_r <= 1'b0;
      clk_sync_r <= 1'b0;
      clk_prev_r <= 1'b0;
    end else begin
      clk_meta_r <= conv_clk_pin;
      clk_sync_r <= clk_meta_r;
      clk_prev_r <= clk_sync_r;
    end
  end

  // Word sync is safe only because the source holds levels across a start edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ana_meta_r <= '0;
      ana_sync_r <= '0;
      gain_meta_r <= 1'b1;
      gain_sync_r <= 1'b1;
      ref_meta_r <= PAS_REF_GROUND;
      ref_sync_r <= PAS_REF_GROUND;
      ext_meta_r <= '0;
      ext_sync_r <= '0;
    end else begin
      ana_meta_r <= analog_in;
      ana_sync_r <= ana_meta_r;
      gain_meta_r <= gain_select;
      gain_sync_r <= gain_meta_r;
      ref_meta_r <= ref_select;
      ref_sync_r <= ref_meta_r;
      ext_meta_r <= ext_ref_mv;
      ext_sync_r <= ext_meta_r;
    end
  end

  assign start_edge = clk_sync_r && !clk_prev_r;
  // An edge during a running conversion is dropped rather than restarting it
  assign take = start_edge && !busy_r;

  pas_quantiser u_quant (
    .sample(ana_sync_r),
    .gain_one(gain_sync_r),
    .ref_select(ref_sync_r),
    .ext_ref_mv(ext_sync_r),
    .code(q_code)
  );

  assign decay = !take && (idle_cnt_r == CNT_W'(STALE_CYC - 1));

  // Pipeline shifts on each taken edge; decay empties it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s0_r <= PAS_WORD_RST;
      s1_r <= PAS_WORD_RST;
      s2_r <= PAS_WORD_RST;
      s0_v_r <= 1'b0;
      s1_v_r <= 1'b0;
      s2_v_r <= 1'b0;
    end else if (take) begin
      s0_r <= q_code;
      s1_r <= s0_r;
      s2_r <= s1_r;
      s0_v_r <= 1'b1;
      s1_v_r <= s0_v_r;
      s2_v_r <= s1_v_r;
    end else if (decay) begin
      s0_v_r <= 1'b0;
      s1_v_r <= 1'b0;
      s2_v_r <= 1'b0;
    end
  end

  // Conversion timer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_r <= 1'b0;
      conv_cnt_r <= '0;
    end else if (take) begin
      busy_r <= 1'b1;
      conv_cnt_r <= CONV_W'(PAS_CONV_CYC - 2);
    end else if (busy_r) begin
      if (conv_cnt_r == '0) begin
        busy_r <= 1'b0;
      end else begin
        conv_cnt_r <= conv_cnt_r - 1'b1;
      end
    end
  end

  assign done = busy_r && (conv_cnt_r == '0);
  assign upd = done && s2_v_r;

  // Word and flag share one register, so they never disagree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result.result_word <= PAS_WORD_RST;
      result.out_of_range_flag <= 1'b0;
    end else if (upd) begin
      result.result_word <= s2_r;
      result.out_of_range_flag <= (s2_r == PAS_CODE_MIN) || (s2_r == PAS_CODE_MAX);
    end
  end

  // Idle timer; wraps at the refresh point so refresh repeats while stopped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_cnt_r <= '0;
    end else if (take) begin
      idle_cnt_r <= '0;
    end else if (idle_cnt_r == CNT_W'(REFRESH_CYC - 1)) begin
      idle_cnt_r <= '0;
    end else begin
      idle_cnt_r <= idle_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refresh_pulse <= 1'b0;
    end else begin
      refresh_pulse <= !take && (idle_cnt_r == CNT_W'(REFRESH_CYC - 1));
    end
  end

  // Decay set wins over the clear from a fresh result
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result_stale <= 1'b0;
    end else if (decay) begin
      result_stale <= 1'b1;
    end else if (upd) begin
      result_stale <= 1'b0;
    end
  end

  AST_SAMPLE_BOTH: assert property (@(posedge clk) disable iff (!rst_b)
    take |=> (s0_r == $past(q_code)) && s0_v_r)
    else $error("Sample not captured on start edge");

  AST_CONV_TIME: assert property (@(posedge clk) disable iff (!rst_b)
    (take && s1_v_r && !decay) |-> ##CONV_LAT (result.result_word == $past(s1_r, 7)))
    else $error("Result not output after conversion time");

  AST_BUSY_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    take |=> busy_r [*6] ##1 !busy_r)
    else $error("Conversion length wrong");

  // A reload of the timer mid-conversion would show up as a count that fails to step down
  AST_NO_RESTART: assert property (@(posedge clk) disable iff (!rst_b)
    (busy_r && (conv_cnt_r != '0)) |=> busy_r && (conv_cnt_r == $past(conv_cnt_r) - 1'b1))
    else $error("Conversion restarted while busy");

  AST_PIPE_ADVANCE: assert property (@(posedge clk) disable iff (!rst_b)
    (take && s0_v_r) |=> s1_v_r && (s1_r == $past(s0_r)))
    else $error("Pipeline did not advance");

  AST_OF_MATCH: assert property (@(posedge clk) disable iff (!rst_b)
    result.out_of_range_flag ==
      ((result.result_word == PAS_CODE_MIN) || (result.result_word == PAS_CODE_MAX)))
    else $error("Out-of-range flag disagrees with word");

  AST_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    !upd |=> $stable(result))
    else $error("Result changed without an update");

  AST_REFRESH: assert property (@(posedge clk) disable iff (!rst_b)
    refresh_pulse |-> ($past(idle_cnt_r) == CNT_W'(REFRESH_CYC - 1)) && $past(!take))
    else $error("Refresh at wrong idle count");

  AST_DECAY: assert property (@(posedge clk) disable iff (!rst_b)
    decay |=> result_stale && !s0_v_r && !s2_v_r)
    else $error("Decay not recorded");

  AST_TAKE_LEN: assert property (@(posedge clk) disable iff (!rst_b)
    take |-> ##BUSY_LEN done)
    else $error("Conversion did not end in time");

  COV_TAKE: cover property (@(posedge clk) disable iff (!rst_b) take);
  COV_UPDATE: cover property (@(posedge clk) disable iff (!rst_b) upd);
  COV_OVERFLOW: cover property (@(posedge clk) disable iff (!rst_b)
    upd ##1 result.out_of_range_flag);
  COV_REFRESH: cover property (@(posedge clk) disable iff (!rst_b) refresh_pulse);
endmodule

// File: rtl/pas_pkg.sv
/*
  Constants and carrier types for the pipelined sampling converter model.
  Assumes a 100 MHz system clock; analog levels arrive as signed millivolt words.
*/
package pas_pkg;
  localparam int PAS_DATA_W = 12;
  localparam int PAS_MV_W = 16;
  localparam int PAS_CLK_NS = 10;
  localparam int PAS_CONV_NS = 70;
  localparam int PAS_CONV_CYC = (PAS_CONV_NS + PAS_CLK_NS - 1) / PAS_CLK_NS;
  localparam int PAS_REFRESH_US = 500;
  localparam int PAS_REFRESH_CYC = (PAS_REFRESH_US * 1000) / PAS_CLK_NS;
  localparam int PAS_MIN_RATE_HZ = 20000;
  localparam int PAS_STALE_CYC = (1000000000 / PAS_MIN_RATE_HZ) / PAS_CLK_NS;
  localparam int PAS_FULL_SCALE_SHIFT = 12;
  localparam logic [PAS_MV_W-1:0] PAS_REF_HI_MV = 16'h1000;
  localparam logic [PAS_MV_W-1:0] PAS_REF_LO_MV = 16'h0800;
  localparam logic signed [PAS_DATA_W-1:0] PAS_CODE_MIN = 12'sh800;
  localparam logic signed [PAS_DATA_W-1:0] PAS_CODE_MAX = 12'sh7ff;
  localparam logic [PAS_DATA_W-1:0] PAS_WORD_RST = 12'h000;

  typedef enum logic [1:0] {
    PAS_REF_GROUND = 2'b00,
    PAS_REF_TO_REF = 2'b01,
    PAS_REF_TO_SUPPLY = 2'b10,
    PAS_REF_UNUSED = 2'b11
  } pas_ref_sel_e;

  typedef struct packed {
    logic signed [PAS_MV_W-1:0] positive_analog_input;
    logic signed [PAS_MV_W-1:0] negative_analog_input;
  } pas_sample_s;

  typedef struct packed {
    logic out_of_range_flag;
    logic [PAS_DATA_W-1:0] result_word;
  } pas_result_s;
endpackage

// File: rtl/pas_quantiser.sv
/*
  Quantiser: turns one differential sample into a saturated two's complement code.
  Assumes inputs are stable in the cycle they are used; purely combinational.
*/
`timescale 1ns/1ps
module pas_quantiser (
  input wire pas_pkg::pas_sample_s sample,
  input wire logic gain_one,
  input wire pas_pkg::pas_ref_sel_e ref_select,
  input wire logic [pas_pkg::PAS_MV_W-1:0] ext_ref_mv,
  output logic signed [pas_pkg::PAS_DATA_W-1:0] code
);
  import pas_pkg::*;

  logic signed [PAS_MV_W:0] diff;
  logic signed [31:0] num;
  logic signed [31:0] den;
  logic signed [31:0] quo;

  // Both inputs are differenced from the same captured word
  assign diff = 17'(sample.positive_analog_input) - 17'(sample.negative_analog_input);

  always_comb begin
    num = 32'(diff) <<< PAS_FULL_SCALE_SHIFT;
    if (!gain_one) begin
      num = num <<< 1;
    end
    case (ref_select)
      PAS_REF_TO_REF: den = 32'(PAS_REF_LO_MV);
      PAS_REF_TO_SUPPLY: den = (ext_ref_mv == '0) ? 32'sh1 : 32'(ext_ref_mv);
      default: den = 32'(PAS_REF_HI_MV);
    endcase
    quo = num / den;
    // Saturate so the extreme codes double as the out-of-range marks
    if (quo > 32'(PAS_CODE_MAX)) begin
      code = PAS_CODE_MAX;
    end else if (quo < 32'(PAS_CODE_MIN)) begin
      code = PAS_CODE_MIN;
    end else begin
      code = quo[PAS_DATA_W-1:0];
    end
  end
endmodule

// File: testbench/pas_host_model.sv
/*
  Host model: makes the conversion clock and latches each result word.
  Assumes a free-running clk; the bench may drop run mid-period, just after a rise.
*/
`timescale 1ns/1ps
module pas_host_model #(
  parameter int PERIOD = 12
) (
  input wire logic clk,
  input wire logic run,
  input wire pas_pkg::pas_result_s result,
  output logic conv_clk_pin,
  output logic pin_rise,
  output pas_pkg::pas_result_s latched
);
  import pas_pkg::*;
  int phase = 0;
  initial begin
    conv_clk_pin = 1'b0;
    pin_rise = 1'b0;
    latched = '0;
  end
  // A started period always runs to its end, so high and low times stay legal
  always @(posedge clk) begin
    pin_rise <= 1'b0;
    if (run || phase != 0) begin
      phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
      conv_clk_pin <= (phase < PERIOD / 2);
      if (phase == 0) begin
        pin_rise <= 1'b1;
        latched <= result;
      end
    end else begin
      conv_clk_pin <= 1'b0;
    end
  end
endmodule

// File: testbench/testbench.sv
/*
  Self-checking bench for pas_converter with the host capture model.
  Assumes shortened refresh and decay counts and one 100 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
  import pas_pkg::*;
  localparam int REF_C = 64;
  localparam int STALE_C = 20;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic run = 1'b0;
  logic gain_select = 1'b1;
  logic conv_clk_pin, pin_rise, refresh_pulse, result_stale;
  pas_sample_s analog_in = '0;
  pas_ref_sel_e ref_select = PAS_REF_GROUND;
  logic [PAS_MV_W-1:0] ext_ref_mv = 16'h03e8;
  pas_result_s result, latched;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  pas_converter #(.REFRESH_CYC(REF_C), .STALE_CYC(STALE_C)) u_dut (.clk(clk), .rst_b(rst_b),
    .conv_clk_pin(conv_clk_pin), .analog_in(analog_in), .gain_select(gain_select),
    .ref_select(ref_select), .ext_ref_mv(ext_ref_mv), .result(result),
    .refresh_pulse(refresh_pulse), .result_stale(result_stale));
  pas_host_model #(.PERIOD(12)) u_host (.clk(clk), .run(run), .result(result),
    .conv_clk_pin(conv_clk_pin), .pin_rise(pin_rise), .latched(latched));

  function automatic pas_sample_s mk(int d);
    mk.positive_analog_input = 16'(d + 100);
    mk.negative_analog_input = 16'h0064;
  endfunction
  // Division truncates toward zero, as the converter's code does
  function automatic pas_result_s expect_of(int d);
    int vref;
    longint v;
    vref = (ref_select == PAS_REF_TO_REF) ? 2048 :
      (ref_select == PAS_REF_TO_SUPPLY) ? int'(ext_ref_mv) : 4096;
    v = longint'(d) * 4096 * (gain_select ? 1 : 2) / vref;
    if (v > 2047) v = 2047;
    if (v < -2048) v = -2048;
    expect_of.result_word = v[11:0];
    expect_of.out_of_range_flag = (v == 2047) || (v == -2048);
  endfunction
  task automatic cmp_res(string what, pas_result_s exp, pas_result_s got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_bit(string what, logic exp, logic got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic cmp_int(string what, int exp, int got);
    total_checks++;
    if (got != exp) begin
      failures++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_rise();
    int n;
    n = 0;
    do begin tick(1); n++; end while (pin_rise !== 1'b1 && n < 40);
    cmp_bit("conversion clock edge", 1'b1, pin_rise);
  endtask
  // Samples follow each other at the fastest legal spacing
  // Fixed-size list with a count keeps the argument plain for every simulator
  task automatic run_seq(input int d[10], input int cnt);
    int i;
    @(posedge clk);
    analog_in <= mk(d[0]);
    run <= 1'b1;
    for (i = 0; i < cnt + 3; i++) begin
      wait_rise();
      if (i >= 3) cmp_res("latched result", expect_of(d[i-3]), latched);
      if (i + 1 < cnt) begin
        repeat (6) @(posedge clk);
        analog_in <= mk(d[i+1]);
      end
    end
    @(posedge clk);
    run <= 1'b0;
    #1;
    cmp_bit("decay flag after updates", 1'b0, result_stale);
  endtask
  task automatic test_stream();
    cmp_res("result after reset", '0, result);
    run_seq('{0, 1, -1, 2046, 2047, 5000, -2047, -2048, -5000, 7}, 10);
    $display("test stream done");
  endtask
  task automatic test_idle();
    int n;
    pas_result_s held;
    held = result;
    n = 0;
    do begin tick(1); n++; end while (result_stale !== 1'b1 && n < STALE_C + 20);
    cmp_bit("decay flag", 1'b1, result_stale);
    n = 0;
    do begin tick(1); n++; end while (refresh_pulse !== 1'b1 && n < REF_C + 20);
    cmp_bit("refresh pulse", 1'b1, refresh_pulse);
    n = 0;
    do begin tick(1); n++; end while (refresh_pulse !== 1'b1 && n < REF_C + 20);
    cmp_int("refresh spacing", REF_C, n);
    cmp_res("result held while idle", held, result);
    $display("test idle done");
  endtask
  task automatic test_modes();
    int g;
    int r;
    for (g = 0; g < 2; g++) begin
      for (r = 0; r < 4; r++) begin
        @(posedge clk);
        gain_select <= g[0];
        ref_select <= pas_ref_sel_e'(r);
        run_seq('{300, -300, 1100, 0, 0, 0, 0, 0, 0, 0}, 3);
      end
    end
    $display("test modes done");
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Whole run needs about 1000 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    tick(2);
    test_stream();
    test_idle();
    test_modes();
    test_idle();
    summarize();
  end
endmodule
